// ### logic/scs_pkg.sv
// constants and types of the conversion sequencer
package scs_pkg;
  localparam int unsigned NBITS = 18;
  localparam logic [17:0] CODE_MID = 18'h20000;
  localparam logic [17:0] CODE_MAX_SB = 18'h3ffff;
  localparam logic [17:0] CODE_MIN_SB = 18'h00000;
  localparam logic [17:0] CODE_MAX_TC = 18'h1ffff;
  localparam logic [17:0] CODE_MIN_TC = 18'h20000;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned IDLE_LIMIT_US = 1000;
  localparam int unsigned IDLE_LIMIT_CYC = IDLE_LIMIT_US * CLK_MHZ;
  localparam logic [1:0] MODE_WARP = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_IMPULSE = 2'h2;
  localparam logic [2:0] ACQ_WARP = 3'h2;
  localparam logic [2:0] ACQ_NORMAL = 3'h3;
  localparam logic [2:0] ACQ_IMPULSE = 3'h5;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_RESULT = 8'h08;
  localparam logic [7:0] A_RAW = 8'h0c;
  localparam int unsigned C_MODE_LSB = 0;
  localparam int unsigned C_PAR18 = 2;
  localparam int unsigned C_PD = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  typedef enum logic [4:0] {
    ST_ACQ   = 5'b00001,
    ST_OPEN  = 5'b00010,
    ST_GND   = 5'b00100,
    ST_TRIAL = 5'b01000,
    ST_CODE  = 5'b10000
  } scs_state_e;
endpackage

// ### logic/scs_sar_if.sv
// sar search core link between sequencer and search engine
`timescale 1ns/1ns
interface scs_sar_if;
  logic        start;
  logic        comp_hi;
  logic        done;
  logic [17:0] trial;
  logic [17:0] result;
  modport seq (output start, output comp_hi, input done, input trial, input result);
  modport eng (input start, input comp_hi, output done, output trial, output result);
endinterface

// ### logic/scs_sar_engine.sv
// bit-by-bit successive approximation search
`timescale 1ns/1ns
module scs_sar_engine (
  input  wire logic hclk,
  input  wire logic hresetn,
  scs_sar_if.eng    sar
);
  logic [17:0] trial_q;
  logic [17:0] bit_q;
  logic        busy_q;
  logic        done_q;

  assign sar.trial  = trial_q;
  assign sar.result = trial_q;
  assign sar.done   = done_q;

  // R3 msb first search
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trial_q <= 18'h00000;
      bit_q   <= 18'h00000;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sar.start) begin
        trial_q <= scs_pkg::CODE_MID;
        bit_q   <= scs_pkg::CODE_MID;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (!sar.comp_hi)
          trial_q <= (trial_q & ~bit_q) | (bit_q >> 1);
        else
          trial_q <= trial_q | (bit_q >> 1);
        bit_q <= bit_q >> 1;
        if (bit_q == 18'h00001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ### logic/scs_sequencer.sv
// conversion sequencer top with ahb-lite registers
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - falling start after acquisition begins conversion
// R2 - open sample switches, then ground arrays
// R3 - test 18 weighted bits, msb first
// R4 - form code, then drop busy
// R5 - result belongs to current sample
// R6 - warp mode fastest, 1 ms accuracy window
// R7 - host discards stale warp results
// R8 - normal mode, no interval limit
// R9 - impulse mode powers down between conversions
// R10 - coding select ignored in 18-bit parallel
// R11 - midscale 20000 binary, 00000 twos
// R12 - overrange saturates at maximum code
// R13 - underrange saturates at minimum code
// R14 - result held in output register
// R15 - coding select high means straight binary
// R16 - busy high through whole conversion
module scs_sequencer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        conversion_start_n,
  input  wire logic        coding_select,
  input  wire logic        comparator_hi,
  input  wire logic        overrange,
  input  wire logic        underrange,
  output logic             busy,
  output logic             sample_switch_pos,
  output logic             sample_switch_neg,
  output logic             array_to_input,
  output logic             array_to_reference_ground,
  output logic      [17:0] cap_switch,
  output logic             low_power,
  output logic      [17:0] data_out,
  output logic             stale_result
);
  scs_sar_if sar ();
  scs_sar_engine u_eng (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sar     (sar)
  );

  scs_pkg::scs_state_e state_q;
  logic [2:0]  cnt_q;
  logic [1:0]  cnv_sync_q;
  logic [1:0]  cmp_sync_q;
  logic [1:0]  cs_sync_q;
  logic [1:0]  ov_sync_q;
  logic [1:0]  un_sync_q;
  logic        cnv_prev_q;
  logic [31:0] ctrl_q;
  logic [17:0] raw_q;
  logic [17:0] result_q;
  logic [31:0] idle_q;
  logic        stale_q;
  logic        aph_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        cnv_fall;
  logic        acq_done;
  logic [2:0]  acq_len;
  logic [1:0]  mode;
  logic        idle_long;
  logic        twos;
  logic [17:0] code_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnv_sync_q <= 2'h3;
      cmp_sync_q <= 2'h0;
      cs_sync_q  <= 2'h3;
      ov_sync_q  <= 2'h0;
      un_sync_q  <= 2'h0;
      cnv_prev_q <= 1'b1;
    end else begin
      cnv_sync_q <= {cnv_sync_q[0], conversion_start_n};
      cmp_sync_q <= {cmp_sync_q[0], comparator_hi};
      cs_sync_q  <= {cs_sync_q[0], coding_select};
      ov_sync_q  <= {ov_sync_q[0], overrange};
      un_sync_q  <= {un_sync_q[0], underrange};
      cnv_prev_q <= cnv_sync_q[1];
    end
  end

  assign cnv_fall = cnv_prev_q & ~cnv_sync_q[1];
  assign mode     = ctrl_q[scs_pkg::C_MODE_LSB +: 2];
  assign acq_len  = (mode == scs_pkg::MODE_WARP)   ? scs_pkg::ACQ_WARP :
                    (mode == scs_pkg::MODE_NORMAL) ? scs_pkg::ACQ_NORMAL :
                    scs_pkg::ACQ_IMPULSE;
  assign acq_done = (cnt_q >= acq_len);
  assign idle_long = (idle_q >= 32'(scs_pkg::IDLE_LIMIT_CYC));

  // R1 start only once acquisition done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= scs_pkg::ST_ACQ;
      cnt_q   <= 3'h0;
    end else begin
      case (state_q)
        scs_pkg::ST_ACQ: begin
          if (!acq_done)
            cnt_q <= cnt_q + 3'h1;
          if (acq_done && cnv_fall) begin
            state_q <= scs_pkg::ST_OPEN;
          end
        end
        // R2 switches open first
        scs_pkg::ST_OPEN: state_q <= scs_pkg::ST_GND;
        scs_pkg::ST_GND: state_q <= scs_pkg::ST_TRIAL;
        // R3 engine walks the bits
        scs_pkg::ST_TRIAL: begin
          if (sar.done)
            state_q <= scs_pkg::ST_CODE;
        end
        // R4 code formed then busy drops
        scs_pkg::ST_CODE: begin
          state_q <= scs_pkg::ST_ACQ;
          cnt_q   <= 3'h0;
        end
        default: state_q <= scs_pkg::ST_ACQ;
      endcase
    end
  end

  assign sar.start   = (state_q == scs_pkg::ST_GND);
  assign sar.comp_hi = cmp_sync_q[1];

  // R10 R15 coding polarity, parallel forces binary
  assign twos = ~cs_sync_q[1] & ~ctrl_q[scs_pkg::C_PAR18];

  // R11 R12 R13 coding and clamping
  always_comb begin
    if (ov_sync_q[1])
      code_d = twos ? scs_pkg::CODE_MAX_TC : scs_pkg::CODE_MAX_SB;
    else if (un_sync_q[1])
      code_d = twos ? scs_pkg::CODE_MIN_TC : scs_pkg::CODE_MIN_SB;
    else
      code_d = twos ? (sar.result ^ scs_pkg::CODE_MID) : sar.result;
  end

  // R5 R14 result of this sample held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 18'h00000;
      raw_q    <= 18'h00000;
    end else if (state_q == scs_pkg::ST_TRIAL && sar.done) begin
      result_q <= code_d;
      raw_q    <= sar.result;
    end
  end

  // R6 R8 interval tracked in every mode, stale flag set by reset in any mode, afterwards for warp only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_q  <= 32'(scs_pkg::IDLE_LIMIT_CYC);
      stale_q <= 1'b1;
    end else begin
      if (state_q == scs_pkg::ST_OPEN) begin
        // R7 flag for host to discard
        stale_q <= idle_long && (mode == scs_pkg::MODE_WARP);
        idle_q  <= 32'h0;
      end else if (!idle_long) begin
        idle_q <= idle_q + 32'h1;
      end
    end
  end

  // R16 busy over whole conversion
  assign busy = (state_q != scs_pkg::ST_ACQ);
  assign sample_switch_pos = (state_q == scs_pkg::ST_ACQ);
  assign sample_switch_neg = (state_q == scs_pkg::ST_ACQ);
  assign array_to_input = (state_q == scs_pkg::ST_ACQ) || (state_q == scs_pkg::ST_OPEN);
  assign array_to_reference_ground = ~array_to_input;
  assign cap_switch = (state_q == scs_pkg::ST_TRIAL) ? sar.trial : 18'h00000;
  // R9 impulse power down in acquisition once acq_done
  assign low_power = (mode == scs_pkg::MODE_IMPULSE) && (state_q == scs_pkg::ST_ACQ)
                     && acq_done;
  assign data_out = result_q;
  assign stale_result = stale_q;

  // ahb-lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      aph_q  <= hsel & htrans[1];
      wr_q   <= hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl_q <= scs_pkg::CTRL_RST;
    else if (aph_q && wr_q && addr_q == scs_pkg::A_CTRL)
      ctrl_q <= {28'h0000000, hwdata[3:0]};
  end

  always_comb begin
    hrdata = 32'h0;
    if (aph_q && !wr_q) begin
      case (addr_q)
        scs_pkg::A_CTRL:   hrdata = ctrl_q;
        scs_pkg::A_STATUS: hrdata = {27'h0, low_power, stale_q, idle_long, twos, busy};
        scs_pkg::A_RESULT: hrdata = {14'h0, result_q};
        scs_pkg::A_RAW:    hrdata = {14'h0, raw_q};
        default:           hrdata = 32'h0;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

// ### test/scs_checker.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
module scs_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy,
  input wire logic        sample_switch_pos,
  input wire logic        sample_switch_neg,
  input wire logic        array_to_input,
  input wire logic        array_to_reference_ground,
  input wire logic [17:0] cap_switch,
  input wire logic        low_power,
  input wire logic [17:0] data_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_open_then_gnd;
    $rose(busy) |-> !sample_switch_pos && array_to_input ##1 array_to_reference_ground;
  endproperty
  a_open_then_gnd: assert property (p_open_then_gnd) else $error("switch order wrong");
  property p_msb_first;
    $rose(busy) |-> ##2 cap_switch[17] && (cap_switch[16:0] == 17'h0);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
  property p_idle_no_trial;
    !busy |-> cap_switch == 18'h0;
  endproperty
  a_idle_no_trial: assert property (p_idle_no_trial) else $error("trial while idle");
  property p_code_before_fall;
    $fell(busy) |-> $stable(data_out);
  endproperty
  a_code_before_fall: assert property (p_code_before_fall) else $error("code late");
  property p_busy_span;
    $rose(busy) |-> busy [*8] ##[10:25] !busy;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
  property p_result_held;
    !busy && $past(!busy) |-> $stable(data_out);
  endproperty
  a_result_held: assert property (p_result_held) else $error("result moved");
  property p_switch_pair;
    sample_switch_pos == sample_switch_neg && array_to_reference_ground == !array_to_input;
  endproperty
  a_switch_pair: assert property (p_switch_pair) else $error("switch pair differs");
  property p_acq_back;
    $fell(busy) |-> sample_switch_pos && array_to_input;
  endproperty
  a_acq_back: assert property (p_acq_back) else $error("no acquisition");
  property p_lp_idle;
    low_power |-> !busy;
  endproperty
  a_lp_idle: assert property (p_lp_idle) else $error("low power in conversion");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response wrong");
endmodule
bind scs_sequencer scs_checker i_chk (.hclk, .hresetn, .hreadyout, .hresp, .busy,
  .sample_switch_pos, .sample_switch_neg, .array_to_input, .array_to_reference_ground,
  .cap_switch, .low_power, .data_out);

// ### test/scs_host_model.sv
// host that pulses conversion start on request
`timescale 1ns/1ns
module scs_host_model (
  input  wire logic hclk,
  input  wire logic go,
  input  wire logic busy,
  output logic      conversion_start_n
);
  initial conversion_start_n = 1'b1;
  always @(posedge hclk) begin
    if (go === 1'b1 && busy === 1'b0) begin
      repeat (8) @(posedge hclk);
      conversion_start_n <= 1'b0;
      repeat (4) @(posedge hclk);
      conversion_start_n <= 1'b1;
    end
  end
endmodule

// ### test/scs_sequencer_tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ns
module scs_sequencer_tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, rd_ph = 0, busy_p = 0;
  logic        csel = 0, comp = 0, ovr = 0, und = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic        hreadyout, hresp, cnv_n, busy;
  logic [17:0] data_out;
  logic [31:0] q[$];
  int          error_cnt = 0, samples_checked = 0;
  always #25 hclk = ~hclk;
  scs_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conversion_start_n(cnv_n),
    .coding_select(csel), .comparator_hi(comp), .overrange(ovr), .underrange(und),
    .busy(busy), .sample_switch_pos(), .sample_switch_neg(), .array_to_input(),
    .array_to_reference_ground(), .cap_switch(), .low_power(), .data_out(data_out),
    .stale_result());
  scs_host_model i_host (.hclk(hclk), .go(go), .busy(busy), .conversion_start_n(cnv_n));
  task results;
    if (q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] pending expected 0 seen %0d", q.size());
    end
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a}; hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d; rd_ph <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task conv(input logic par);
    logic [17:0] raw;
    raw = ovr ? 18'h3ffff : und ? 18'h00000 : {18{comp}};
    q.push_back({14'h0, (csel || par) ? raw : raw ^ scs_pkg::CODE_MID});
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    for (int i = 0; i < 200 && !(busy_p === 1'b1 && busy === 1'b0); i++) @(posedge hclk);
    repeat (10) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    busy_p <= busy;
    if (rd_ph === 1'b1) chk("hrdata", q.pop_front(), hrdata);
    if (busy_p === 1'b1 && busy === 1'b0) chk("data_out", q.pop_front(), {14'h0, data_out});
  end
  initial begin
    #400000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    results;
  end
  initial begin
    void'($urandom(97));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, scs_pkg::A_CTRL, scs_pkg::CTRL_RST);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b0, scs_pkg::A_STATUS, 32'h0000_000e);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, scs_pkg::A_CTRL, m);
      bus(1'b0, scs_pkg::A_CTRL, m);
      for (int k = 0; k < 6; k++) begin
        csel <= $urandom; comp <= $urandom; ovr <= (k == 4); und <= (k >= 4);
        @(posedge hclk);
        conv(1'b0);
      end
      $display("test mode %0d done", m);
    end
    bus(1'b1, scs_pkg::A_CTRL, 32'h5);
    csel <= 1'b0; comp <= 1'b1; ovr <= 1'b0; und <= 1'b0;
    @(posedge hclk);
    conv(1'b1);
    $display("test parallel done");
    results;
  end
endmodule
